// [hdl/pic_defines.vh]
/*
 * Shared constants of the priority interrupt controller: register word
 * offsets, field layouts, reset values and fixed levels.
 * Assumes a 32-bit APB slave in which every register takes one aligned word.
 */
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define PIC_OFS_PRIO_A 8'h00
`define PIC_OFS_PRIO_B 8'h04
`define PIC_OFS_PRIO_C 8'h08
`define PIC_OFS_PRIO_D 8'h0C
`define PIC_OFS_PRIO_E 8'h10
`define PIC_OFS_SENSE_CTRL 8'h14
`define PIC_OFS_STATUS 8'h18

// ==========================================================================
// Reset values
// ==========================================================================
`define PIC_RST_PRIO 16'h0000
`define PIC_RST_EDGE_SEL 1'b0
`define PIC_RST_SENSE 8'h00

// ==========================================================================
// Field layout of the sense control register
// ==========================================================================
`define PIC_CTL_NMI_LEVEL_BIT 15
`define PIC_CTL_EDGE_SEL_BIT 8
`define PIC_CTL_SENSE_MSB 7
`define PIC_CTL_SENSE_LSB 0

// ==========================================================================
// Field layout of the status register
// ==========================================================================
`define PIC_STS_REQ_BIT 11
`define PIC_STS_LVL_MSB 10
`define PIC_STS_LVL_LSB 6
`define PIC_STS_SRC_MSB 5
`define PIC_STS_SRC_LSB 0

// ==========================================================================
// Priority fields and sources
// ==========================================================================
`define PIC_FIELD_W 4
`define PIC_NUM_PRIO_REGS 5
`define PIC_NUM_EXT_PINS 8
`define PIC_NUM_PERIPH_FIELDS 11
`define PIC_SUBS_PER_FIELD 4
`define PIC_E_LOW_FIELD_MASK 16'hFFF0
`define PIC_NMI_LEVEL 5'h10
`define PIC_SRC_NMI 6'h00
`define PIC_SRC_EXT_BASE 6'h01
`define PIC_SRC_PERIPH_BASE 6'h09

`endif

// [hdl/pic_controller.v]
/*
 * Priority interrupt controller: five priority registers, a sense control
 * register and a status register behind an APB slave, pin synchronisers,
 * edge and level request detection, priority selection against the CPU
 * mask, and the request to the CPU with its active-low mirror pin.
 * Assumes one clock, an asynchronous active-high reset, and a CPU that
 * pulses cpu_accept when it replaces an instruction by exception handling
 * and loads the accepted level into its mask within one cycle of it.
 */
// Implementation choices: the APB interface to the registers and the register addresses.
//
// Functional notes
// R1: Each four-bit level runs zero (lowest) to fifteen (highest), taken from its field.
// R2: Each priority register holds four fields at 15-12, 11-8, 7-4, 3-0.
// R3: Two peripherals sharing one field always receive the identical level.
// R4: Reset clears all priority registers; standby leaves them unchanged.
// R5: Lowest field of priority register E reads zero; software writes zero.
// R6: Control bit 15 shows the nonmaskable pin level, read only.
// R7: Control bits 14 to 9 read zero; software writes zero.
// R8: Control bit 8 picks nonmaskable edge: zero falling, one rising.
// R9: Control bits 7..0 pick pin 0..7 sense: zero low level, one falling edge.
// R10: Reset initialises the control register; standby keeps writable bits.
// R11: Highest level wins; ties fall to fixed default and within-module order.
// R12: A request reaches the CPU only if its level exceeds the CPU mask.
// R13: An accepted request drives the active-low request-out pin low, mirroring the CPU request.
// R14: The CPU samples the request while decoding its next instruction.
// R15: The CPU pushes status word then program counter onto the stack.
// R16: The CPU loads the accepted level into its mask field.
// R17: Level or peripheral request: request-out returns high after acceptance unless higher accepted.
// R18: Edge request: request-out returns high when the CPU starts exception handling.
// R19: The CPU fetches the handler address from the vector table, undelayed.
// R20: An edge-detected external request is held pending once only.
// R21: A level external request withdrawn before acceptance counts as never made.
// R22: Peripheral requests are levels held while the module's status flag is set.
// R23: Nonmaskable and external pins are synchronised before detection.
`timescale 1ns/1ps
`include "pic_defines.vh"

module pic_controller #(
    parameter NUM_EXT = 8,
    parameter NUM_PFLD = 11
) (
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire nmi_pin,
    input wire [NUM_EXT-1:0] external_request_pins_n,
    input wire [NUM_PFLD*4-1:0] periph_req,
    input wire [3:0] cpu_mask_level,
    input wire cpu_accept,
    output reg cpu_req_q,
    output reg [4:0] cpu_req_level_q,
    output reg [5:0] cpu_req_src_q,
    output reg request_out_pin_n_q
);

    // ======================================================================
    // Register state
    // ======================================================================
    reg [15:0] prio_a_q;
    reg [15:0] prio_b_q;
    reg [15:0] prio_c_q;
    reg [15:0] prio_d_q;
    reg [15:0] prio_e_q;
    reg nonmaskable_edge_select_q;
    reg [7:0] ext_pin_sense_select_q;

    // ======================================================================
    // Pin synchronisers and detection state
    // ======================================================================
    reg [NUM_EXT:0] sync1_q;
    reg [NUM_EXT:0] sync2_q;
    reg [NUM_EXT:0] sync3_q;
    reg [NUM_EXT:0] filt_q;
    reg [NUM_EXT-1:0] edge_pend_q;
    reg nmi_pend_q;
    reg holdoff_q;

    wire [79:0] prio_flat;
    wire nonmaskable_pin_level;
    wire [NUM_EXT-1:0] ext_level_n;
    wire [NUM_EXT-1:0] ext_fall;
    wire nmi_edge;
    wire [NUM_EXT-1:0] sense_edge;
    wire [NUM_EXT-1:0] ext_req;
    wire [NUM_EXT-1:0] ext_clear;
    wire nmi_clear;
    wire wr_en;
    wire setup;

    reg best_hit;
    reg [4:0] best_lvl;
    reg [5:0] best_src;
    reg [4:0] lvl;
    reg [31:0] rd_mux;
    reg rd_err;
    integer i;
    integer s;
    integer j;
    integer k;

    // Field f of the flat vector: f=0 is register A bits 15-12, f=19 is E bits 3-0.
    assign prio_flat = {prio_a_q, prio_b_q, prio_c_q, prio_d_q, prio_e_q}; // R2

    // Filtered level of each pin; index NUM_EXT is the nonmaskable pin.
    assign nonmaskable_pin_level = filt_q[NUM_EXT];
    assign ext_level_n = filt_q[NUM_EXT-1:0];

    // Control bit 7 belongs to pin 0, bit 0 to pin 7.
    genvar g;
    generate
        for (g = 0; g < NUM_EXT; g = g + 1) begin : g_sense
            assign sense_edge[g] = ext_pin_sense_select_q[NUM_EXT-1-g]; // R9
        end
    endgenerate

    // ======================================================================
    // Three-stage synchronisers with agreement filter
    // ======================================================================
    // The filtered level follows only when the second and third stages agree,
    // so a single metastable resolution never produces a false edge.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= {(NUM_EXT+1){1'b1}};
            sync2_q <= {(NUM_EXT+1){1'b1}};
            sync3_q <= {(NUM_EXT+1){1'b1}};
            filt_q <= {(NUM_EXT+1){1'b1}};
        end else if (clk_en) begin
            sync1_q <= {nmi_pin, external_request_pins_n}; // R23
            sync2_q <= sync1_q; // R23
            sync3_q <= sync2_q;
            // Each process keeps its own loop index so no variable has two drivers.
            for (j = 0; j <= NUM_EXT; j = j + 1) begin
                if (sync2_q[j] == sync3_q[j]) begin
                    filt_q[j] <= sync3_q[j]; // R23
                end
            end
        end
    end

    // Edges are taken on the filtered levels as they update, with no cycle of detection latency.
    assign ext_fall = filt_q[NUM_EXT-1:0] & ~sync3_q[NUM_EXT-1:0] &
                      ~(sync2_q[NUM_EXT-1:0] ^ sync3_q[NUM_EXT-1:0]);
    assign nmi_edge = (sync2_q[NUM_EXT] == sync3_q[NUM_EXT]) &&
                      (sync3_q[NUM_EXT] != filt_q[NUM_EXT]) &&
                      (sync3_q[NUM_EXT] == nonmaskable_edge_select_q); // R8

    // ======================================================================
    // Pending requests
    // ======================================================================
    // Acceptance clears only the edge latch of the source the CPU took.
    assign nmi_clear = cpu_accept && cpu_req_q && (cpu_req_src_q == `PIC_SRC_NMI);
    generate
        for (g = 0; g < NUM_EXT; g = g + 1) begin : g_clr
            assign ext_clear[g] = cpu_accept && cpu_req_q &&
                                  (cpu_req_src_q == `PIC_SRC_EXT_BASE + g);
        end
    endgenerate

    // A new edge in the clearing cycle wins, so no event is lost.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nmi_pend_q <= 1'b0;
            edge_pend_q <= {NUM_EXT{1'b0}};
        end else if (clk_en) begin
            if (nmi_edge) begin
                nmi_pend_q <= 1'b1;
            end else if (nmi_clear) begin
                nmi_pend_q <= 1'b0; // R18
            end
            for (k = 0; k < NUM_EXT; k = k + 1) begin
                if (!sense_edge[k]) begin
                    edge_pend_q[k] <= 1'b0;
                end else if (ext_fall[k]) begin
                    edge_pend_q[k] <= 1'b1; // R20
                end else if (ext_clear[k]) begin
                    edge_pend_q[k] <= 1'b0; // R18
                end
            end
        end
    end

    // Level mode follows the pin directly, so a withdrawn request vanishes.
    assign ext_req = (sense_edge & edge_pend_q) | (~sense_edge & ~ext_level_n); // R21

    // ======================================================================
    // Priority selection
    // ======================================================================
    // Sources are scanned in default order; only a strictly higher level
    // displaces the current pick, so ties keep the earlier source.
    always @* begin
        best_hit = 1'b0;
        best_lvl = 5'h00;
        best_src = `PIC_SRC_NMI;
        lvl = 5'h00;
        if (nmi_pend_q) begin
            best_hit = 1'b1;
            best_lvl = `PIC_NMI_LEVEL;
        end
        for (i = 0; i < NUM_EXT; i = i + 1) begin
            lvl = {1'b0, prio_flat[79-4*i -: 4]}; // R1
            if (ext_req[i] && (!best_hit || lvl > best_lvl)) begin // R11
                best_hit = 1'b1;
                best_lvl = lvl;
                best_src = `PIC_SRC_EXT_BASE + i[5:0];
            end
        end
        // All four sources of a shared field read the same nibble.
        for (i = 0; i < NUM_PFLD; i = i + 1) begin
            lvl = {1'b0, prio_flat[79-4*(i+8) -: 4]}; // R3
            for (s = 3; s >= 0; s = s - 1) begin
                if (periph_req[4*i+s] && (!best_hit || lvl > best_lvl)) begin // R22
                    best_hit = 1'b1;
                    best_lvl = lvl;
                    best_src = `PIC_SRC_PERIPH_BASE + i[5:0] * 6'd4 + s[5:0];
                end
            end
        end
    end

    // ======================================================================
    // Request to the CPU and request-out pin
    // ======================================================================
    // One cycle after an acceptance the request is held off, so a level
    // source is not offered again before the CPU has raised its mask.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            holdoff_q <= 1'b0;
            cpu_req_q <= 1'b0;
            cpu_req_level_q <= 5'h00;
            cpu_req_src_q <= `PIC_SRC_NMI;
            request_out_pin_n_q <= 1'b1;
        end else if (clk_en) begin
            holdoff_q <= cpu_accept && cpu_req_q;
            if (!holdoff_q && !(cpu_accept && cpu_req_q) && best_hit &&
                (best_src == `PIC_SRC_NMI || best_lvl > {1'b0, cpu_mask_level})) begin // R12
                cpu_req_q <= 1'b1;
                cpu_req_level_q <= best_lvl;
                cpu_req_src_q <= best_src;
                request_out_pin_n_q <= 1'b0; // R13
            end else begin
                cpu_req_q <= 1'b0; // R17
                request_out_pin_n_q <= 1'b1; // R18
            end
        end
    end

    // ======================================================================
    // APB slave
    // ======================================================================
    // Every transfer completes with one access cycle; pready is registered.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    always @* begin
        rd_err = 1'b0;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `PIC_OFS_PRIO_A: rd_mux = {16'h0000, prio_a_q};
            `PIC_OFS_PRIO_B: rd_mux = {16'h0000, prio_b_q};
            `PIC_OFS_PRIO_C: rd_mux = {16'h0000, prio_c_q};
            `PIC_OFS_PRIO_D: rd_mux = {16'h0000, prio_d_q};
            `PIC_OFS_PRIO_E: rd_mux = {16'h0000, prio_e_q & `PIC_E_LOW_FIELD_MASK}; // R5
            `PIC_OFS_SENSE_CTRL: begin
                rd_mux = {16'h0000, nonmaskable_pin_level, 6'h00, // R6 R7
                          nonmaskable_edge_select_q, ext_pin_sense_select_q};
            end
            `PIC_OFS_STATUS: begin
                rd_mux = {20'h0_0000, cpu_req_q, cpu_req_level_q, cpu_req_src_q};
            end
            default: rd_err = 1'b1;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= setup;
            pslverr <= setup && rd_err;
            if (setup && !pwrite && !rd_err) begin
                prdata <= rd_mux;
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Only reset and APB writes touch these registers; there is no standby clear path.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prio_a_q <= `PIC_RST_PRIO; // R4
            prio_b_q <= `PIC_RST_PRIO;
            prio_c_q <= `PIC_RST_PRIO;
            prio_d_q <= `PIC_RST_PRIO;
            prio_e_q <= `PIC_RST_PRIO;
            nonmaskable_edge_select_q <= `PIC_RST_EDGE_SEL; // R10
            ext_pin_sense_select_q <= `PIC_RST_SENSE;
        end else if (clk_en && wr_en) begin
            case (paddr)
                `PIC_OFS_PRIO_A: prio_a_q <= pwdata[15:0];
                `PIC_OFS_PRIO_B: prio_b_q <= pwdata[15:0];
                `PIC_OFS_PRIO_C: prio_c_q <= pwdata[15:0];
                `PIC_OFS_PRIO_D: prio_d_q <= pwdata[15:0];
                `PIC_OFS_PRIO_E: prio_e_q <= pwdata[15:0] & `PIC_E_LOW_FIELD_MASK; // R5
                `PIC_OFS_SENSE_CTRL: begin
                    nonmaskable_edge_select_q <= pwdata[`PIC_CTL_EDGE_SEL_BIT]; // R8
                    ext_pin_sense_select_q <= pwdata[7:0]; // R9
                end
                default: prio_a_q <= prio_a_q;
            endcase
        end
    end

endmodule

// [test/pic_cpu_model.sv]
/*
 * Behavioural CPU core facing the interrupt controller: takes offered
 * requests promptly or slowly and loads the taken level into its mask.
 * Assumes the controller's request outputs are registered on sys_clk.
 */
`timescale 1ns/1ps
module pic_cpu_model (
    input wire sys_clk,
    input wire rst,
    input wire auto_en,
    input wire slow,
    input wire mask_wr,
    input wire [3:0] mask_val,
    input wire cpu_req_q,
    input wire [4:0] cpu_req_level_q,
    output reg cpu_accept,
    output reg [3:0] cpu_mask_level
);
    // ======================================================================
    // Acceptance
    // ======================================================================
    reg [1:0] wait_q;
    reg [4:0] lvl_q;
    reg [1:0] exc_step_q;
    // A slow core waits two extra cycles so late acceptance is exercised too.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_accept <= 1'b0;
            cpu_mask_level <= 4'h0;
            wait_q <= 2'h0;
            lvl_q <= 5'h00;
            exc_step_q <= 2'h0;
        end else begin
            cpu_accept <= 1'b0;
            // Step 1 stacks the status word, step 2 the program counter, step 3
            // reads the vector and branches; no new request is taken meanwhile.
            if (cpu_accept) begin
                exc_step_q <= 2'h1;
            end else if (exc_step_q != 2'h0) begin
                exc_step_q <= exc_step_q + 2'h1;
            end
            if (mask_wr) begin
                cpu_mask_level <= mask_val;
            end else if (cpu_accept) begin
                cpu_mask_level <= lvl_q[4] ? 4'hF : lvl_q[3:0];
            end else if (auto_en && cpu_req_q && exc_step_q == 2'h0) begin
                if (!slow || wait_q == 2'h2) begin
                    cpu_accept <= 1'b1;
                    lvl_q <= cpu_req_level_q;
                    wait_q <= 2'h0;
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
        end
    end
endmodule

// [test/pic_controller_assertions.sv]
/*
 * Concurrent checks on the controller's ports.
 * Assumes clk_en held high and the CPU takes requests by a one-cycle pulse.
 */
`timescale 1ns/1ps
module pic_checker #(
    parameter NUM_EXT = 8,
    parameter NUM_PFLD = 11
) (
    input wire sys_clk,
    input wire rst,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire [3:0] cpu_mask_level,
    input wire cpu_accept,
    input wire cpu_req_q,
    input wire [4:0] cpu_req_level_q,
    input wire [5:0] cpu_req_src_q,
    input wire request_out_pin_n_q
);
    // ======================================================================
    // Sequences
    // ======================================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_taken;
        cpu_req_q && cpu_accept;
    endsequence
    sequence s_off2;
        !cpu_req_q ##1 !cpu_req_q;
    endsequence
    // ======================================================================
    // Properties
    // ======================================================================
    a_pin_mirror: assert property (request_out_pin_n_q == !cpu_req_q)
        else $error("request pin does not mirror request");
    a_above_mask: assert property (cpu_req_q && !cpu_req_level_q[4] |->
        cpu_req_level_q[3:0] > $past(cpu_mask_level)) else $error("level not above mask");
    a_accept_holdoff: assert property (s_taken |=> s_off2)
        else $error("request not withdrawn after acceptance");
    a_ctrl_zero: assert property (pready && !pwrite && paddr == 8'h14 |->
        prdata[14:9] == 6'h00 && prdata[31:16] == 16'h0000) else $error("reserved bits set");
    a_prio_e_low: assert property (pready && !pwrite && paddr == 8'h10 |->
        prdata[3:0] == 4'h0) else $error("unused field reads nonzero");
    a_nmi_top: assert property (cpu_req_q && cpu_req_src_q == 6'h00 |->
        cpu_req_level_q == 5'h10) else $error("nonmaskable level wrong");
    a_level_range: assert property (cpu_req_q && cpu_req_src_q != 6'h00 |->
        cpu_req_level_q <= 5'h0F) else $error("maskable level out of range");
    a_reset_idle: assert property ($fell(rst) |-> !cpu_req_q && request_out_pin_n_q)
        else $error("request active after reset");
endmodule
bind pic_controller pic_checker #(.NUM_EXT(NUM_EXT), .NUM_PFLD(NUM_PFLD)) pic_checker_i (
    .sys_clk(sys_clk), .rst(rst), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .cpu_mask_level(cpu_mask_level), .cpu_accept(cpu_accept),
    .cpu_req_q(cpu_req_q), .cpu_req_level_q(cpu_req_level_q),
    .cpu_req_src_q(cpu_req_src_q), .request_out_pin_n_q(request_out_pin_n_q));

// [test/tb_top.sv]
/*
 * Self-checking bench: APB register accesses, request selection, masking
 * and acceptance through the CPU model.
 * Assumes the APB slave answers one cycle after setup.
 */
`timescale 1ns/1ps
module tb_top;
    reg sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg nmi_pin = 1'b1, auto_en = 1'b0, slow = 1'b0, mask_wr = 1'b0, serr;
    reg [7:0] paddr = 8'h00, ext_n = 8'hFF;
    reg [31:0] pwdata = 32'h0000_0000, rd;
    reg [43:0] periph = 44'h000_0000_0000;
    reg [3:0] mask_val = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, cpu_accept, cpu_req_q, request_out_pin_n_q;
    wire [3:0] cpu_mask_level;
    wire [4:0] cpu_req_level_q;
    wire [5:0] cpu_req_src_q;
    integer err_count = 0, n_checks = 0, i;
    // ======================================================================
    // Instances and clock
    // ======================================================================
    pic_controller #(.NUM_EXT(8), .NUM_PFLD(11)) pic_controller_i (.sys_clk(sys_clk),
        .rst(rst), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmi_pin(nmi_pin), .external_request_pins_n(ext_n), .periph_req(periph),
        .cpu_mask_level(cpu_mask_level), .cpu_accept(cpu_accept), .cpu_req_q(cpu_req_q),
        .cpu_req_level_q(cpu_req_level_q), .cpu_req_src_q(cpu_req_src_q),
        .request_out_pin_n_q(request_out_pin_n_q));
    pic_cpu_model pic_cpu_model_i (.sys_clk(sys_clk), .rst(rst), .auto_en(auto_en),
        .slow(slow), .mask_wr(mask_wr), .mask_val(mask_val), .cpu_req_q(cpu_req_q),
        .cpu_req_level_q(cpu_req_level_q), .cpu_accept(cpu_accept),
        .cpu_mask_level(cpu_mask_level));
    // The clock toggles every 10 ns for a 50 MHz rate.
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // ======================================================================
    // Tasks
    // ======================================================================
    task wrap_up;
        begin
            if (err_count == 0 && n_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) begin
                @(posedge sys_clk);
            end
            rd = prdata;
            serr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // An idle edge between transfers keeps each strobe assigned once per step.
            @(posedge sys_clk);
        end
    endtask
    task settle(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
        end
    endtask
    task mask(input [3:0] v);
        begin
            mask_wr <= 1'b1;
            mask_val <= v;
            @(posedge sys_clk);
            mask_wr <= 1'b0;
        end
    endtask
    // Level and source are only meaningful while a request is offered.
    task req_is(input on, input [4:0] l, input [5:0] s);
        begin
            if (on) chk({cpu_req_q, request_out_pin_n_q, cpu_req_level_q, cpu_req_src_q},
                {2'b10, l, s});
            else chk({cpu_req_q, request_out_pin_n_q}, 2'b01);
        end
    endtask
    // ======================================================================
    // Watchdog and tests
    // ======================================================================
    // Tests need about 200 cycles; 10000 leaves a wide margin.
    initial begin
        #200000;
        err_count = err_count + 1;
        wrap_up;
    end
    // Main sequence of register and request scenarios.
    initial begin
        settle(2);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (i = 0; i < 6; i = i + 1) begin
            apb(1'b0, {i[5:0], 2'b00}, 0);
            chk(rd, (i == 5) ? 32'h0000_8000 : 32'h0000_0000);
        end
        apb(1'b0, 8'h1C, 0);
        chk({rd[30:0], serr}, 32'h0000_0001);
        for (i = 0; i < 5; i = i + 1) begin
            apb(1'b1, {i[5:0], 2'b00}, (i == 4) ? 32'h0000_FFF0 : 32'h0000_FFFF);
            apb(1'b0, {i[5:0], 2'b00}, 0);
            chk(rd, (i == 4) ? 32'h0000_FFF0 : 32'h0000_FFFF);
        end
        apb(1'b1, 8'h14, 32'h0000_01FF);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h0000_81FF);
        for (i = 0; i < 6; i = i + 1) apb(1'b1, {i[5:0], 2'b00}, 0);
        apb(1'b1, 8'h08, 32'h0000_3000);
        apb(1'b1, 8'h0C, 32'h0000_0009);
        periph <= (44'h1 << 3) | (44'h1 << 31);
        settle(3);
        req_is(1'b1, 5'd9, 6'd40);
        mask(4'h9);
        settle(3);
        req_is(1'b0, 0, 0);
        apb(1'b1, 8'h0C, 32'h0000_0003);
        mask(4'h2);
        settle(3);
        req_is(1'b1, 5'd3, 6'd12);
        periph <= 44'h000_0000_0005;
        settle(3);
        req_is(1'b1, 5'd3, 6'd11);
        periph <= 44'h1 << 38;
        apb(1'b1, 8'h10, 32'h0000_0700);
        settle(3);
        req_is(1'b1, 5'd7, 6'd47);
        auto_en <= 1'b1;
        settle(6);
        req_is(1'b0, 0, 0);
        chk(cpu_mask_level, 4'h7);
        auto_en <= 1'b0;
        periph <= 44'h000_0000_0000;
        mask(4'h0);
        apb(1'b1, 8'h00, 32'h0000_4000);
        ext_n <= 8'hFE;
        settle(8);
        req_is(1'b1, 5'd4, 6'd1);
        ext_n <= 8'hFF;
        settle(8);
        req_is(1'b0, 0, 0);
        apb(1'b1, 8'h14, 32'h0000_0080);
        for (i = 0; i < 2; i = i + 1) begin
            ext_n <= 8'hFE;
            settle(2);
            ext_n <= 8'hFF;
            settle(2);
        end
        settle(8);
        req_is(1'b1, 5'd4, 6'd1);
        slow <= 1'b1;
        auto_en <= 1'b1;
        settle(12);
        auto_en <= 1'b0;
        mask(4'h0);
        settle(4);
        req_is(1'b0, 0, 0);
        mask(4'hF);
        nmi_pin <= 1'b0;
        settle(8);
        req_is(1'b1, 5'd16, 6'd0);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h0000_0080);
        auto_en <= 1'b1;
        settle(8);
        auto_en <= 1'b0;
        req_is(1'b0, 0, 0);
        apb(1'b1, 8'h14, 32'h0000_0100);
        nmi_pin <= 1'b1;
        settle(8);
        req_is(1'b1, 5'd16, 6'd0);
        apb(1'b0, 8'h18, 0);
        chk(rd, 32'h0000_0C00);
        wrap_up;
    end
endmodule
